// >>> rtl/fli_pkg.sv
// Package: register map, fields, keys and sizes of the flash lock and programming block
package fli_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] FLI_IDX_LOCK_RANGE = 8'h47;
  localparam logic [7:0] FLI_IDX_PROTECT_CONTROL = 8'h48;
  localparam logic [7:0] FLI_IDX_PROG_CONTROL = 8'h4d;
  localparam logic [7:0] FLI_IDX_PROG_ADDR_LOW = 8'h4e;
  localparam logic [7:0] FLI_IDX_PROG_ADDR_HIGH = 8'h4f;
  localparam logic [7:0] FLI_IDX_FLASH_KEY_REG = 8'h50;
  localparam logic [7:0] FLI_IDX_STATUS = 8'h51;
  // Field positions
  localparam int FLI_POS_PROTECT_ARM = 0;
  localparam int FLI_POS_IAP_ENABLE = 0;
  localparam int FLI_POS_TABLE_WRITE_OPTION = 6;
  localparam int FLI_POS_SEL_LOW = 0;
  // Reset values
  localparam logic [7:0] FLI_RST_BYTE = 8'h00;
  localparam logic [2:0] FLI_RST_ADDR_LOW = 3'h0;
  localparam logic [3:0] FLI_RST_ADDR_HIGH = 4'h0;
  // Keys written to the flash key register
  localparam logic [7:0] FLI_KEY_PROTECT = 8'hc5;
  localparam logic [7:0] FLI_KEY_IAP = 8'hb4;
  // Sizes
  localparam int FLI_FLASH_AW = 12;
  localparam int FLI_LOCK_UNIT_SHIFT = 7;
  localparam int FLI_BLOCK_SHIFT = 5;
  localparam logic [4:0] FLI_BLOCK_LAST = 5'h1f;
  localparam int FLI_BLOCK_WORDS = 32;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    FLI_SEQ_IDLE = 3'b001,
    FLI_SEQ_RUN = 3'b010,
    FLI_SEQ_DRAIN = 3'b100
  } fli_seq_state_t;
endpackage

// >>> rtl/fli_seq_if.sv
// Interface: handshake between lock controller and block programming sequencer
`timescale 1ns/1ps
`default_nettype none
interface fli_seq_if;
  logic start;
  logic [fli_pkg::FLI_FLASH_AW-1:0] base;
  logic busy;
  logic done;
  modport ctl (output start, output base, input busy, input done);
  modport seq (input start, input base, output busy, output done);
endinterface
`default_nettype wire

// >>> rtl/fli_prog_seq.sv
// Block programming sequencer: copies one 32-word RAM block into flash
`timescale 1ns/1ps
`default_nettype none
module fli_prog_seq #(
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  fli_seq_if.seq sif,
  output logic [4:0] ram_idx_o,
  input wire logic [DW-1:0] ram_data_i,
  output logic flash_we_o,
  output logic [fli_pkg::FLI_FLASH_AW-1:0] flash_waddr_o,
  output logic [DW-1:0] flash_wdata_o
);
  import fli_pkg::*;

  typedef struct packed {
    fli_seq_state_t st;
    logic [4:0] idx;
    logic [4:0] ridx;
    logic [6:0] base;
    logic we;
    logic [FLI_FLASH_AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic done;
  } fli_seq_reg_t;

  fli_seq_reg_t s;
  fli_seq_reg_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.we = 1'b0;
    case (s.st)
      FLI_SEQ_IDLE: begin
        if (sif.start) begin
          next_s.st = FLI_SEQ_RUN;
          next_s.base = sif.base[FLI_FLASH_AW-1:FLI_BLOCK_SHIFT];
          next_s.idx = 5'h00;
          // Word 0 is already on the RAM index, so fetch runs one word ahead
          next_s.ridx = 5'h01;
        end
      end
      FLI_SEQ_RUN: begin
        // RAM word for idx arrives one cycle after its index
        next_s.we = 1'b1;
        next_s.wdata = ram_data_i;
        next_s.waddr = {s.base, s.idx};
        if (s.idx == FLI_BLOCK_LAST) begin
          next_s.st = FLI_SEQ_DRAIN;
        end else begin
          next_s.idx = s.idx + 5'h01;
          next_s.ridx = s.ridx + 5'h01;
        end
      end
      FLI_SEQ_DRAIN: begin
        next_s.done = 1'b1;
        next_s.st = FLI_SEQ_IDLE;
      end
      default: begin
        next_s.st = FLI_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '{st: FLI_SEQ_IDLE, default: '0};
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign sif.busy = (s.st != FLI_SEQ_IDLE);
  assign sif.done = s.done;
  assign ram_idx_o = s.ridx;
  assign flash_we_o = s.we;
  assign flash_waddr_o = s.waddr;
  assign flash_wdata_o = s.wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [6:0] we_cnt;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      we_cnt <= 7'h00;
    end else if (ce_i) begin
      if (s.done) begin
        we_cnt <= 7'h00;
      end else if (s.we) begin
        we_cnt <= we_cnt + 7'h01;
      end
    end
  end

  AST_BLOCK_32_WORDS: assert property (
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    s.done |-> we_cnt == 7'(FLI_BLOCK_WORDS))
    else $error("block copy did not write 32 words");

  AST_WRITE_IN_BLOCK: assert property (
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (sif.start && s.st == FLI_SEQ_IDLE) |-> ##2 flash_we_o &&
      flash_waddr_o == {$past(sif.base[FLI_FLASH_AW-1:FLI_BLOCK_SHIFT], 2), 5'h00})
    else $error("first programmed word not at aligned block base");
endmodule
`default_nettype wire

// >>> rtl/fli_top.sv
// Flash lock and in-application programming controller with Wishbone registers
//
// Notes on behaviour
// - Table access from code inside the locked region may reach all flash.
// - Table access from code outside the locked region reaches unlocked flash only.
// - Each unit of the lock range value covers 128 flash words.
// - Table writes program flash only when the table write option is set.
// - Programming copies a 32-word RAM block into flash per operation.
// - Programming address bits 0 to 4 read as zero; targets are block aligned.
// - Target address is eight low bits plus four high bits, loaded by software.
// - Table write option is bit 6 of a code option word, default off.
`timescale 1ns/1ps
`default_nettype none
module fli_top #(
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Code option word holding the table write option
  input wire logic [15:0] code_opt_i,
  // Table access request from the core
  input wire logic tab_req_i,
  input wire logic tab_wr_i,
  input wire logic [fli_pkg::FLI_FLASH_AW-1:0] tab_pc_i,
  input wire logic [fli_pkg::FLI_FLASH_AW-1:0] tab_addr_i,
  output logic tab_ok_o,
  output logic tab_deny_o,
  output logic flash_rd_o,
  output logic [fli_pkg::FLI_FLASH_AW-1:0] flash_raddr_o,
  // Block programming path
  output logic [4:0] ram_idx_o,
  input wire logic [DW-1:0] ram_data_i,
  output logic flash_we_o,
  output logic [fli_pkg::FLI_FLASH_AW-1:0] flash_waddr_o,
  output logic [DW-1:0] flash_wdata_o,
  output logic prog_busy_o
);
  import fli_pkg::*;

  typedef struct packed {
    logic [7:0] lock_range;
    logic protect_arm_bit;
    logic in_app_prog_enable;
    logic [2:0] addr_low;
    logic [3:0] addr_high;
    logic lock_on;
    logic iap_key;
    logic ack;
    logic [7:0] rdata;
    logic ok;
    logic deny;
    logic rd;
    logic [FLI_FLASH_AW-1:0] raddr;
    logic start;
    logic busy;
  } fli_top_reg_t;

  fli_top_reg_t s;
  fli_top_reg_t next_s;
  fli_seq_if sif ();

  // True when a flash word lies below the end of the locked region
  function automatic logic in_locked(input logic [FLI_FLASH_AW-1:0] a,
                                     input logic [7:0] range);
    in_locked = {3'h0, a} < {range, 7'h00};
  endfunction

  logic [FLI_FLASH_AW-1:0] prog_addr;
  logic wb_hit;
  logic wb_wr;
  logic [7:0] wb_idx;
  logic pc_locked;
  logic tgt_locked;
  logic rd_allowed;
  logic wr_allowed;

  assign prog_addr = {s.addr_high, s.addr_low, 5'h00};
  assign wb_hit = wb_cyc_i && wb_stb_i && !s.ack;
  assign wb_wr = wb_hit && wb_we_i && wb_sel_i[FLI_POS_SEL_LOW];
  assign wb_idx = wb_adr_i[9:2];
  assign pc_locked = in_locked(tab_pc_i, s.lock_range);
  assign rd_allowed = !s.lock_on || pc_locked || !in_locked(tab_addr_i, s.lock_range);
  assign tgt_locked = in_locked(prog_addr, s.lock_range);
  assign wr_allowed = code_opt_i[FLI_POS_TABLE_WRITE_OPTION] && s.in_app_prog_enable &&
                      s.iap_key && !sif.busy && !s.start &&
                      (!s.lock_on || pc_locked || !tgt_locked);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.ack = wb_hit;
    next_s.ok = 1'b0;
    next_s.deny = 1'b0;
    next_s.rd = 1'b0;
    next_s.start = 1'b0;
    next_s.busy = sif.busy || s.start;
    // Table access from the core
    if (tab_req_i) begin
      if (!tab_wr_i) begin
        next_s.ok = rd_allowed;
        next_s.deny = !rd_allowed;
        next_s.rd = rd_allowed;
        next_s.raddr = tab_addr_i;
      end else begin
        // Key is single use
        next_s.ok = wr_allowed;
        next_s.deny = !wr_allowed;
        next_s.start = wr_allowed;
        next_s.iap_key = 1'b0;
      end
    end
    // Register reads
    next_s.rdata = 8'h00;
    if (wb_hit && !wb_we_i) begin
      case (wb_idx)
        FLI_IDX_LOCK_RANGE: next_s.rdata = s.lock_range;
        FLI_IDX_PROTECT_CONTROL: next_s.rdata = {7'h00, s.protect_arm_bit};
        FLI_IDX_PROG_CONTROL: next_s.rdata = {7'h00, s.in_app_prog_enable};
        FLI_IDX_PROG_ADDR_LOW: next_s.rdata = {s.addr_low, 5'h00};
        FLI_IDX_PROG_ADDR_HIGH: next_s.rdata = {4'h0, s.addr_high};
        FLI_IDX_STATUS: next_s.rdata = {5'h00, s.busy, s.iap_key, s.lock_on};
        default: next_s.rdata = 8'h00;
      endcase
    end
    // Register writes; a key written in the same cycle as a table write wins
    if (wb_wr) begin
      case (wb_idx)
        FLI_IDX_LOCK_RANGE: next_s.lock_range = wb_dat_i[7:0];
        FLI_IDX_PROTECT_CONTROL: next_s.protect_arm_bit = wb_dat_i[FLI_POS_PROTECT_ARM];
        FLI_IDX_PROG_CONTROL: next_s.in_app_prog_enable = wb_dat_i[FLI_POS_IAP_ENABLE];
        FLI_IDX_PROG_ADDR_LOW: next_s.addr_low = wb_dat_i[7:5];
        FLI_IDX_PROG_ADDR_HIGH: next_s.addr_high = wb_dat_i[3:0];
        FLI_IDX_FLASH_KEY_REG: begin
          if (wb_dat_i[7:0] == FLI_KEY_PROTECT && s.protect_arm_bit) begin
            next_s.lock_on = 1'b1;
          end
          if (wb_dat_i[7:0] == FLI_KEY_IAP && s.in_app_prog_enable) begin
            next_s.iap_key = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '{lock_range: FLI_RST_BYTE, addr_low: FLI_RST_ADDR_LOW,
             addr_high: FLI_RST_ADDR_HIGH, raddr: '0, rdata: FLI_RST_BYTE, default: 1'b0};
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign sif.start = s.start;
  assign sif.base = prog_addr;

  fli_prog_seq #(
    .DW(DW)
  ) u_seq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .sif(sif),
    .ram_idx_o(ram_idx_o),
    .ram_data_i(ram_data_i),
    .flash_we_o(flash_we_o),
    .flash_waddr_o(flash_waddr_o),
    .flash_wdata_o(flash_wdata_o)
  );

  assign wb_ack_o = s.ack;
  assign wb_dat_o = {24'h000000, s.rdata};
  assign tab_ok_o = s.ok;
  assign tab_deny_o = s.deny;
  assign flash_rd_o = s.rd;
  assign flash_raddr_o = s.raddr;
  assign prog_busy_o = s.busy;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_WB_ACK_SINGLE: assert property (
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  AST_LOCKED_PC_READS_ALL: assert property (
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (tab_req_i && !tab_wr_i && in_locked(tab_pc_i, s.lock_range))
      |=> tab_ok_o && flash_rd_o && flash_raddr_o == $past(tab_addr_i))
    else $error("read from locked code refused");

  AST_OUTSIDE_PC_DENIED: assert property (
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (tab_req_i && s.lock_on && !in_locked(tab_pc_i, s.lock_range) &&
      (tab_wr_i ? in_locked(prog_addr, s.lock_range) : in_locked(tab_addr_i, s.lock_range)))
      |=> tab_deny_o && !tab_ok_o && !flash_rd_o)
    else $error("outside code reached locked flash");

  AST_WRITE_NEEDS_OPTION: assert property (
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (tab_req_i && tab_wr_i && !code_opt_i[FLI_POS_TABLE_WRITE_OPTION])
      |=> tab_deny_o && !tab_ok_o && !sif.start)
    else $error("table write ran with option off");

  AST_WRITE_NEEDS_KEY: assert property (
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (tab_req_i && tab_wr_i && (!s.iap_key || !s.in_app_prog_enable)) |=> !sif.start)
    else $error("table write started without enable and key");

  AST_ADDR_LOW_READS_ZERO: assert property (
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (wb_hit && !wb_we_i && wb_idx == FLI_IDX_PROG_ADDR_LOW) |=> wb_ack_o && wb_dat_o[4:0] == 5'h00)
    else $error("low programming address bits not zero");
endmodule
`default_nettype wire

// >>> tb/fli_ram_model.sv
// Core-side RAM model: returns the staged word one cycle after its index
`timescale 1ns/1ps
`default_nettype none
module fli_ram_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] idx_i,
  output logic [15:0] data_o
);
  // Each staged word carries its own index so a misordered copy shows
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= 16'h0000;
    end else begin
      data_o <= {8'hc3, 3'h0, idx_i};
    end
  end
endmodule
`default_nettype wire

// >>> tb/fli_top_tb.sv
// Testbench for the flash lock and block programming controller
`timescale 1ns/1ps
`default_nettype none
module fli_top_tb;
  import fli_pkg::*;
  typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} fli_row_t;
  fli_row_t rows [7] = '{
    '{FLI_IDX_LOCK_RANGE, 8'ha5, 8'ha5},
    '{FLI_IDX_PROTECT_CONTROL, 8'h01, 8'h01},
    '{FLI_IDX_PROG_CONTROL, 8'h01, 8'h01},
    '{FLI_IDX_PROG_ADDR_LOW, 8'hff, 8'he0},
    '{FLI_IDX_PROG_ADDR_HIGH, 8'hff, 8'h0f},
    '{FLI_IDX_FLASH_KEY_REG, 8'h12, 8'h00},
    '{8'h60, 8'h33, 8'h00}};
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, tab_req_i = 1'b0, tab_wr_i = 1'b0;
  logic [9:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic [15:0] code_opt_i = 16'hffbf, ram_data_i, flash_wdata_o;
  logic [11:0] tab_pc_i = '0, tab_addr_i = '0, flash_raddr_o, flash_waddr_o;
  logic wb_ack_o, tab_ok_o, tab_deny_o, flash_rd_o, flash_we_o, prog_busy_o;
  logic [4:0] ram_idx_o;
  logic [7:0] q;
  int failures = 0, check_count = 0, cycles = 0, n;

  fli_top #(.DW(16)) dut_u (.clk_i, .rst_n_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .code_opt_i, .tab_req_i,
    .tab_wr_i, .tab_pc_i, .tab_addr_i, .tab_ok_o, .tab_deny_o, .flash_rd_o,
    .flash_raddr_o, .ram_idx_o, .ram_data_i, .flash_we_o, .flash_waddr_o,
    .flash_wdata_o, .prog_busy_o);
  fli_ram_model ram_u (.clk_i, .rst_n_i, .idx_i(ram_idx_o), .data_o(ram_data_i));

  always #10 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up;
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // One table instruction; grant or refusal seen one cycle later
  task automatic tab(input logic w, input logic [11:0] pc, input logic [11:0] a, input logic ok);
    @(posedge clk_i);
    tab_req_i <= 1'b1;
    tab_wr_i <= w;
    tab_pc_i <= pc;
    tab_addr_i <= a;
    @(posedge clk_i);
    tab_req_i <= 1'b0;
    #1;
    chk("grant", {15'h0, tab_ok_o}, {15'h0, ok});
    chk("refusal", {15'h0, tab_deny_o}, {15'h0, !ok});
    if (!w && ok) begin
      chk("read strobe", {15'h0, flash_rd_o}, 16'h0001);
      chk("read address", {4'h0, flash_raddr_o}, {4'h0, a});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      xfer(1'b0, rows[i].idx, 8'h00);
      chk("reset value", {8'h0, q}, 16'h0000);
      xfer(1'b1, rows[i].idx, rows[i].wd);
      xfer(1'b0, rows[i].idx, 8'h00);
      chk("readback", {8'h0, q}, {8'h0, rows[i].rd});
    end
    // Arm the lock over words 0 to 127
    xfer(1'b1, FLI_IDX_FLASH_KEY_REG, FLI_KEY_PROTECT);
    xfer(1'b1, FLI_IDX_LOCK_RANGE, 8'h01);
    xfer(1'b0, FLI_IDX_STATUS, 8'h00);
    chk("lock status", {8'h0, q}, 16'h0001);
    tab(1'b0, 12'd200, 12'd127, 1'b0);
    tab(1'b0, 12'd200, 12'd128, 1'b1);
    tab(1'b0, 12'd50, 12'hfff, 1'b1);
    // Block programming at 0x540, option bit clear first
    xfer(1'b1, FLI_IDX_PROG_ADDR_HIGH, 8'h05);
    xfer(1'b1, FLI_IDX_PROG_ADDR_LOW, 8'h5f);
    xfer(1'b1, FLI_IDX_FLASH_KEY_REG, FLI_KEY_IAP);
    tab(1'b1, 12'd200, 12'h000, 1'b0);
    @(posedge clk_i);
    code_opt_i <= 16'h0040;
    tab(1'b1, 12'd200, 12'h000, 1'b0);
    xfer(1'b1, FLI_IDX_FLASH_KEY_REG, FLI_KEY_IAP);
    tab(1'b1, 12'd200, 12'h000, 1'b1);
    n = 0;
    while (flash_we_o !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("busy during copy", {15'h0, prog_busy_o}, 16'h0001);
    for (int i = 0; i < FLI_BLOCK_WORDS; i++) begin
      chk("write address", {4'h0, flash_waddr_o}, 16'h0540 + 16'(i));
      chk("write data", flash_wdata_o, {8'hc3, 3'h0, 5'(i)});
      @(posedge clk_i);
      #1;
    end
    chk("block length", {15'h0, flash_we_o}, 16'h0000);
    @(posedge clk_i);
    #1;
    chk("busy after copy", {15'h0, prog_busy_o}, 16'h0000);
    // Locked target from outside, then from inside, then while busy
    xfer(1'b1, FLI_IDX_PROG_ADDR_HIGH, 8'h00);
    xfer(1'b1, FLI_IDX_FLASH_KEY_REG, FLI_KEY_IAP);
    tab(1'b1, 12'd200, 12'h000, 1'b0);
    xfer(1'b1, FLI_IDX_FLASH_KEY_REG, FLI_KEY_IAP);
    tab(1'b1, 12'd50, 12'h000, 1'b1);
    xfer(1'b1, FLI_IDX_FLASH_KEY_REG, FLI_KEY_IAP);
    tab(1'b1, 12'd50, 12'h000, 1'b0);
    // Reset in mid-run drops the lock
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    xfer(1'b0, FLI_IDX_STATUS, 8'h00);
    chk("status after reset", {8'h0, q}, 16'h0000);
    wrap_up;
  end
endmodule
`default_nettype wire
